// ===== bpc_defs.vh
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH

// register indices on the plain register port
`define BPC_ADDR_W 3
`define BPC_ADDR_PINS 3'h0
`define BPC_ADDR_DIR 3'h1
`define BPC_ADDR_OPTION 3'h2
`define BPC_ADDR_INTCTL 3'h3
`define BPC_ADDR_STATUS 3'h4

// reset values
`define BPC_DIR_RST 8'hFF
`define BPC_OPTION_RST 8'hFF
`define BPC_LATCH_RST 8'h00
`define BPC_INTCTL_RST 8'h00

// field positions
`define BPC_OPT_PULLUP_N_BIT 7
`define BPC_INT_CHANGE_FLAG_BIT 0
`define BPC_INT_CHANGE_EN_BIT 3
`define BPC_UPPER_LSB 4

`endif

// ===== bpc_sync2.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bus of pin levels
module bpc_sync2 #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rstn,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== bpc_port.v
// Behaviour
// - eight pins, each individually an input or an output.
// - direction 1 tri-states the pin; 0 drives the output latch.
// - one shared active-low option bit enables all pull-ups when cleared.
// - pull-up forced off on any pin currently driven as output.
// - pull-ups are disabled after power-on reset.
// - an enabled peripheral may force a pin to output or input.
// - only pins 7 to 4 take part in change detection.
// - upper pins driven as outputs are excluded from the comparison.
// - upper inputs compared against snapshot latched on each data read.
// - per-pin mismatches ORed into one event setting the change flag.
// - the change event can wake the device from sleep.
// - a lasting mismatch keeps setting the flag; a data read ends it.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.vh"
module bpc_port #(
    parameter WIDTH = 8,
    parameter UPPER = 4
) (
    input wire clk,
    input wire rstn,
    input wire [`BPC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out,
    output reg [WIDTH-1:0] pin_oe,
    output reg [WIDTH-1:0] pullup_on,
    input wire [WIDTH-1:0] periph_force_out,
    input wire [WIDTH-1:0] periph_force_in,
    input wire [WIDTH-1:0] periph_out_value,
    input wire [WIDTH-1:0] periph_out_sel,
    input wire sleeping,
    output reg change_flag,
    output reg change_irq,
    output reg wake_request
);
    reg [WIDTH-1:0] port_b_direction;
    reg [WIDTH-1:0] out_latch;
    reg [7:0] option_config;
    reg change_irq_enable;
    reg [UPPER-1:0] snapshot;
    wire [WIDTH-1:0] pins_sync;
    wire [WIDTH-1:0] eff_dir;
    wire [WIDTH-1:0] drive_value;
    wire [UPPER-1:0] upper_change_pins;
    wire [UPPER-1:0] upper_is_input;
    wire [UPPER-1:0] mismatch;
    wire change_event;
    wire pullup_enable_n;
    wire wr_pins;
    wire wr_dir;
    wire wr_opt;
    wire wr_int;
    wire rd_pins;
    reg [7:0] next_rdata;
    reg next_change_flag;

    // pins come from outside the clock domain
    bpc_sync2 #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pin_in),
        .q(pins_sync)
    );

    assign wr_pins = reg_wr && (reg_addr == `BPC_ADDR_PINS);
    assign wr_dir = reg_wr && (reg_addr == `BPC_ADDR_DIR);
    assign wr_opt = reg_wr && (reg_addr == `BPC_ADDR_OPTION);
    assign wr_int = reg_wr && (reg_addr == `BPC_ADDR_INTCTL);
    assign rd_pins = reg_rd && (reg_addr == `BPC_ADDR_PINS);

    // force-out wins over force-in if a peripheral asserts both
    assign eff_dir = (port_b_direction | periph_force_in)
        & ~periph_force_out;
    assign drive_value = (out_latch & ~periph_out_sel)
        | (periph_out_value & periph_out_sel);
    assign pullup_enable_n = option_config[`BPC_OPT_PULLUP_N_BIT];

    assign upper_change_pins = pins_sync[WIDTH-1:`BPC_UPPER_LSB];
    assign upper_is_input = eff_dir[WIDTH-1:`BPC_UPPER_LSB];
    assign mismatch = (upper_change_pins ^ snapshot) & upper_is_input;
    assign change_event = |mismatch;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_b_direction <= `BPC_DIR_RST;
            out_latch <= `BPC_LATCH_RST;
            option_config <= `BPC_OPTION_RST;
            change_irq_enable <= 1'b0;
        end
        else
        begin
            // direction writes store the value given; overridden bits
            // read back as effective, so a read-modify-write would copy
            // the override into the stored bit
            if (wr_dir)
                port_b_direction <= reg_wdata[WIDTH-1:0];
            if (wr_pins)
                out_latch <= reg_wdata[WIDTH-1:0];
            if (wr_opt)
                option_config <= reg_wdata;
            if (wr_int)
                change_irq_enable <= reg_wdata[`BPC_INT_CHANGE_EN_BIT];
        end
    end

    // snapshot is what the read returns, so the mismatch ends on read
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            snapshot <= {UPPER{1'b0}};
        else if (rd_pins)
            snapshot <= upper_change_pins;
    end

    always @*
    begin
        next_change_flag = change_flag;
        if (wr_int && !reg_wdata[`BPC_INT_CHANGE_FLAG_BIT])
            next_change_flag = 1'b0;
        if (wr_int && reg_wdata[`BPC_INT_CHANGE_FLAG_BIT])
            next_change_flag = 1'b1;
        // a live mismatch beats a software clear
        if (change_event)
            next_change_flag = 1'b1;
    end

    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `BPC_ADDR_PINS:
                next_rdata = pins_sync;
            `BPC_ADDR_DIR:
                next_rdata = eff_dir;
            `BPC_ADDR_OPTION:
                next_rdata = option_config;
            `BPC_ADDR_INTCTL:
            begin
                next_rdata[`BPC_INT_CHANGE_FLAG_BIT] = change_flag;
                next_rdata[`BPC_INT_CHANGE_EN_BIT] = change_irq_enable;
            end
            `BPC_ADDR_STATUS:
                next_rdata = {mismatch, snapshot};
            default:
                next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
            change_flag <= 1'b0;
            change_irq <= 1'b0;
            wake_request <= 1'b0;
            pin_out <= `BPC_LATCH_RST;
            pin_oe <= {WIDTH{1'b0}};
            pullup_on <= {WIDTH{1'b0}};
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            change_flag <= next_change_flag;
            change_irq <= next_change_flag & change_irq_enable;
            // wake needs no enable so a sleeping core always hears it
            wake_request <= sleeping & next_change_flag;
            pin_out <= drive_value;
            pin_oe <= ~eff_dir;
            pullup_on <= {WIDTH{~pullup_enable_n}} & eff_dir;
        end
    end
endmodule
`default_nettype wire

// ===== bpc_port_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.vh"
module bpc_port_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`BPC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] periph_force_out,
    input wire logic [7:0] periph_force_in,
    input wire logic sleeping,
    input wire logic change_flag,
    input wire logic change_irq,
    input wire logic wake_request
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
AST_NO_PULL_ON_OUT: assert property ((pullup_on & pin_oe) == 8'h00)
    else $error("pull-up on output pin");
AST_PULL_OFF: assert property (reg_wr && reg_addr == `BPC_ADDR_OPTION
    && reg_wdata[7] |-> ##2 pullup_on == 8'h00) else $error("pull-up on");
AST_FORCE_OUT: assert property ((pin_oe & $past(periph_force_out))
    == $past(periph_force_out)) else $error("forced output ignored");
AST_FORCE_IN: assert property ((pin_oe & $past(periph_force_in)
    & ~$past(periph_force_out)) == 8'h00) else $error("forced input ignored");
AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
AST_FLAG_HOLD: assert property (change_flag && !(reg_wr
    && reg_addr == `BPC_ADDR_INTCTL) |=> change_flag) else $error("flag lost");
AST_IRQ_CAUSE: assert property (change_irq |->
    change_flag || $past(change_flag)) else $error("irq without flag");
AST_WAKE: assert property (sleeping && change_flag |=> wake_request)
    else $error("no wake");
endmodule
`default_nettype wire

// ===== bpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpc_pin_model (
    input wire logic clk,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    output logic [7:0] pin_in
);
    logic flt = 1'h0;
    // undriven pins wander so a stale level never passes
    always @(posedge clk) flt <= ~flt;
    // device driver, then outside driver, then pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_on | {8{flt}}));
endmodule
`default_nettype wire

// ===== bpc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.vh"
module bpc_port_tb;
    logic clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic sleeping = 1'h0, change_flag, change_irq, wake_request;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, ev = 8'h00, ee = 8'hFF;
    logic [7:0] periph_force_out = 8'h00, periph_force_in = 8'h00;
    logic [7:0] po_val = 8'h00, po_sel = 8'h00;
    logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pullup_on;
    logic [18:0] rows [4] = '{19'h10F0F, 19'h27F7F, 19'h53300, 19'h30808};
    int num_errors = 0, cmp_count = 0, i;
    bpc_port DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .pullup_on, .periph_force_out,
        .periph_force_in, .periph_out_value(po_val), .periph_out_sel(po_sel),
        .sleeping, .change_flag, .change_irq, .wake_request);
    bpc_pin_model pins (.clk, .ext_val(ev), .ext_en(ee), .pin_out, .pin_oe,
        .pullup_on, .pin_in);
    always #12.5 clk = ~clk;
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #125000 num_errors++;
        wrap_up;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        w(1);
        chk(pullup_on, 8'h00);
        chk(pin_oe, 8'h00);
        rd(`BPC_ADDR_DIR, 8'hFF);
        for (i = 0; i < 4; i++)
        begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], rows[i][7:0]);
        end
        wr(`BPC_ADDR_PINS, 8'hA5);
        w(3);
        chk(pin_oe, 8'hF0);
        chk(pin_out, 8'hA5);
        chk(pullup_on, 8'h0F);
        periph_force_out <= 8'h01;
        periph_force_in <= 8'h80;
        po_val <= 8'h02;
        po_sel <= 8'h03;
        w(3);
        chk(pin_oe, 8'h71);
        chk(pin_out, 8'hA6);
        rd(`BPC_ADDR_DIR, 8'h8E);
        periph_force_out <= 8'h00;
        periph_force_in <= 8'h00;
        po_sel <= 8'h00;
        wr(`BPC_ADDR_DIR, 8'hFF);
        w(4);
        rd(`BPC_ADDR_PINS, 8'h00);
        wr(`BPC_ADDR_INTCTL, 8'h08);
        ev <= 8'h0F;
        w(5);
        chk(8'(change_flag), 8'h00);
        ev <= 8'h1F;
        w(5);
        chk(8'(change_flag), 8'h01);
        chk(8'(change_irq), 8'h01);
        rd(`BPC_ADDR_STATUS, 8'h10);
        wr(`BPC_ADDR_INTCTL, 8'h08);
        sleeping <= 1'h1;
        w(2);
        chk(8'(change_flag), 8'h01);
        chk(8'(wake_request), 8'h01);
        sleeping <= 1'h0;
        rd(`BPC_ADDR_PINS, 8'h1F);
        rd(`BPC_ADDR_STATUS, 8'h01);
        wr(`BPC_ADDR_INTCTL, 8'h08);
        w(2);
        chk(8'(change_flag), 8'h00);
        wr(`BPC_ADDR_DIR, 8'h0F);
        w(5);
        chk(8'(change_flag), 8'h00);
        wr(`BPC_ADDR_OPTION, 8'hFF);
        w(2);
        chk(pullup_on, 8'h00);
        wr(`BPC_ADDR_OPTION, 8'h7F);
        w(2);
        chk(pullup_on, 8'h0F);
        rstn <= 1'h0;
        w(2);
        chk(pullup_on, 8'h00);
        chk(pin_oe, 8'h00);
        @(posedge clk);
        rstn <= 1'h1;
        w(2);
        chk(pullup_on, 8'h00);
        rd(`BPC_ADDR_OPTION, 8'hFF);
        wrap_up;
    end
endmodule
bind bpc_port bpc_port_props u_props (.clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pin_oe, .pullup_on, .periph_force_out,
    .periph_force_in, .sleeping, .change_flag, .change_irq, .wake_request);
`default_nettype wire
